/* File: ccc_pkg.sv */
// Constants shared by the call / clear / complement instruction engine.
// Assumes an APB master with 32-bit data and 12-bit byte addresses.
package ccc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_INSTR   = 12'h000;  // Instruction issue and status
  localparam logic [11:0] OFF_PC      = 12'h004;  // Program counter
  localparam logic [11:0] OFF_ACC     = 12'h008;  // Accumulator
  localparam logic [11:0] OFF_FLAGS   = 12'h00C;  // Flag register
  localparam logic [11:0] OFF_BANK    = 12'h010;  // Bank selector
  localparam logic [11:0] OFF_SHADOW  = 12'h014;  // Shadow copies, read only
  localparam logic [11:0] OFF_STACK   = 12'h018;  // Stack top and pointer, read only
  localparam logic [11:0] OFF_WDOG    = 12'h01C;  // Watchdog state, read only
  localparam logic [11:0] OFF_CTRL    = 12'h020;  // Extended set enable
  localparam logic [11:0] OFF_INDEX   = 12'h024;  // Indexed mode base address
  localparam logic [1:0]  DM_WINDOW   = 2'h1;     // paddr[11:10] of data memory window

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          FLAG_Z      = 2;        // Zero flag bit
  localparam int          FLAG_N      = 4;        // Negative flag bit
  localparam int          WD_TMO_BIT  = 16;       // Timeout flag in watchdog register
  localparam int          WD_SLP_BIT  = 17;       // Power-down flag in watchdog register
  localparam logic [20:0] PC_RST      = 21'h000000;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [4:0]  FLAGS_RST   = 5'h00;
  localparam logic [3:0]  BANK_RST    = 4'h0;
  localparam logic [11:0] INDEX_RST   = 12'h000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [6:0]  OP_CALL     = 7'h76;    // 1110 110s
  localparam logic [3:0]  OP_CALL2    = 4'hF;     // 1111 kkkk, second word
  localparam logic [6:0]  OP_CLEAR    = 7'h35;    // 0110 101a
  localparam logic [5:0]  OP_INVERT   = 6'h07;    // 0001 11da
  localparam logic [15:0] OP_KICK     = 16'h0004; // 0000 0000 0000 0100
  localparam logic [7:0]  INDEX_LIMIT = 8'h5F;    // Highest indexed offset, 95
  localparam logic [20:0] PC_STEP     = 21'h000002;
  localparam logic [20:0] PC_RETURN   = 21'h000004;
  localparam logic [3:0]  ACC_BANK_LO = 4'h0;     // Access bank, low half
  localparam logic [3:0]  ACC_BANK_HI = 4'hF;     // Access bank, high half

  // Instruction phases, Gray coded along the issue path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_Q1   = 3'h1,
    ST_Q2   = 3'h3,
    ST_Q3   = 3'h2,
    ST_Q4   = 3'h6
  } ccc_phase_type;

endpackage : ccc_pkg

/* File: ccc_addr_gen.sv */
// Effective data address former for byte-oriented register instructions.
// Assumes bank_selector and index base are stable for the instruction.
`timescale 1ns/100ps
module ccc_addr_gen import ccc_pkg::*; (
  // Instruction fields
  input  wire logic [7:0]  file_addr,     // f field
  input  wire logic        access_sel,    // a field
  // Addressing state
  input  wire logic        ext_enable,    // Extended set enabled
  input  wire logic [3:0]  bank_selector, // Bank selector
  input  wire logic [11:0] index_base,    // Base for indexed mode
  // Result
  output logic      [11:0] eff_addr       // Effective data address
);

  // ----------------------------------------------------------------
  // Address selection
  // ----------------------------------------------------------------
  wire logic        low_half  = (file_addr <= INDEX_LIMIT);           // Offsets 0..95
  wire logic        indexed   = ext_enable & ~access_sel & low_half;
  wire logic [11:0] banked    = {bank_selector, file_addr};
  wire logic [11:0] access_ad = {(low_half ? ACC_BANK_LO : ACC_BANK_HI), file_addr};
  wire logic [11:0] index_ad  = index_base + {4'h0, file_addr};

  assign eff_addr = access_sel ? banked : (indexed ? index_ad : access_ad);

endmodule : ccc_addr_gen

/* File: ccc_core.sv */
// Instruction engine for call, clear, watchdog kick and invert, with APB registers.
// Assumes an APB master on pclk; one instruction is issued per write to OFF_INSTR.
`timescale 1ns/100ps
module ccc_core import ccc_pkg::*; #(
  parameter int DM_DEPTH    = 64,  // Data memory bytes held in flip-flops
  parameter int STACK_DEPTH = 31,  // Return stack entries
  parameter int WD_POST_W   = 7,   // Watchdog postscaler width
  parameter int WD_CNT_W    = 8    // Watchdog counter width
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Status pins
  output logic             timeout_flag,
  output logic             power_down_flag
);

  localparam int DMW = $clog2(DM_DEPTH);
  localparam int SPW = $clog2(STACK_DEPTH);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ccc_phase_type    st_q, st_d;              // Instruction phase
  logic [15:0]      ir_q;                    // Instruction word being executed
  logic             call_pend_q;             // Awaiting call second word
  logic [7:0]       k_low_q;                 // Call target bits 7:0
  logic [20:0]      pc_q;                    // Program counter
  logic [7:0]       acc_q;                   // Accumulator
  logic [4:0]       flags_q;                 // Flag register
  logic [3:0]       bank_q;                  // bank_selector
  logic [7:0]       accumulator_shadow_q;    // Shadow of accumulator
  logic [4:0]       flags_shadow_q;          // Shadow of flags
  logic [3:0]       bank_selector_shadow_q;  // Shadow of bank_selector
  logic [20:0]      stack_q [STACK_DEPTH];   // Return stack
  logic [SPW-1:0]   sp_q;                    // Next free stack slot
  logic [7:0]       dm_q [DM_DEPTH];         // Data memory
  logic [WD_POST_W-1:0] wd_post_q;           // Watchdog postscaler
  logic [WD_CNT_W-1:0]  watchdog_counter_q;  // Watchdog counter
  logic             timeout_flag_q;          // Active low timeout flag
  logic             power_down_flag_q;       // Active low power-down flag
  logic             ext_q;                   // Extended set enable
  logic [11:0]      index_q;                 // Indexed mode base
  logic [31:0]      prdata_q;
  logic             pready_q;
  logic             pslverr_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic access   = psel & penable;
  wire logic take     = access & pready_q;              // Completing edge
  wire logic wr_take  = take & pwrite;
  wire logic sel_ins  = (paddr == OFF_INSTR);
  wire logic sel_dm   = (paddr[11:10] == DM_WINDOW) && ({22'h0, paddr[9:2]} < DM_DEPTH);
  wire logic [DMW-1:0] bus_idx = paddr[DMW+1:2];
  wire logic mapped   = sel_ins | sel_dm | (paddr == OFF_PC) | (paddr == OFF_ACC)
                      | (paddr == OFF_FLAGS) | (paddr == OFF_BANK) | (paddr == OFF_SHADOW)
                      | (paddr == OFF_STACK) | (paddr == OFF_WDOG) | (paddr == OFF_CTRL)
                      | (paddr == OFF_INDEX);
  wire logic issue    = access & ~pready_q & pwrite & sel_ins & (st_q == ST_IDLE);
  wire logic plain    = access & ~pready_q & ~(pwrite & sel_ins);
  wire logic commit   = (st_q == ST_Q4);
  wire logic push_ph  = (st_q == ST_Q3);

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  wire logic is_call1  = ~call_pend_q & (ir_q[15:9] == OP_CALL);
  wire logic is_call2  = call_pend_q;
  wire logic is_clear  = ~call_pend_q & (ir_q[15:9] == OP_CLEAR);
  wire logic is_invert = ~call_pend_q & (ir_q[15:10] == OP_INVERT);
  wire logic is_kick   = ~call_pend_q & (ir_q == OP_KICK);
  wire logic fast_save = ir_q[8];
  wire logic dest_reg  = ir_q[9];
  wire logic [19:0] k_full = {ir_q[11:0], k_low_q};
  wire logic [11:0] eff_addr;
  wire logic [DMW-1:0] ex_idx = eff_addr[DMW-1:0];
  wire logic [7:0]  inv_val  = ~dm_q[ex_idx];
  wire logic [20:0] pc_next  = is_call2 ? {k_full, 1'b0} : pc_q + PC_STEP;
  wire logic [SPW-1:0] sp_next = (sp_q == SPW'(STACK_DEPTH - 1)) ? '0 : sp_q + 1'b1;
  wire logic [SPW-1:0] sp_top  = (sp_q == '0) ? SPW'(STACK_DEPTH - 1) : sp_q - 1'b1;

  // Data memory write port, shared by execution and APB
  wire logic           ex_dm_we = commit & (is_clear | (is_invert & dest_reg));
  wire logic           dm_we    = ex_dm_we | (wr_take & sel_dm);
  wire logic [DMW-1:0] dm_wa    = ex_dm_we ? ex_idx : bus_idx;
  wire logic [7:0]     dm_wd    = ex_dm_we ? (is_clear ? BYTE_RST : inv_val) : pwdata[7:0];

  // Watchdog tick wires
  wire logic wd_post_wrap = &wd_post_q;
  wire logic wd_expire    = wd_post_wrap & (&watchdog_counter_q);

  // Effective address for register instructions
  ccc_addr_gen u_addr (
    .file_addr     (ir_q[7:0]),
    .access_sel    (ir_q[8]),
    .ext_enable    (ext_q),
    .bank_selector (bank_q),
    .index_base    (index_q),
    .eff_addr      (eff_addr)
  );

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  // Four phases per instruction cycle, started by an instruction write
  always_comb begin
    case (st_q)
      ST_IDLE: st_d = issue ? ST_Q1 : ST_IDLE;
      ST_Q1:   st_d = ST_Q2;
      ST_Q2:   st_d = ST_Q3;
      ST_Q3:   st_d = ST_Q4;
      ST_Q4:   st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  // Phase register and instruction latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      ir_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      if (issue) ir_q <= pwdata[15:0];
    end
  end

  // Call word tracking: the second word is captured, never decoded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      call_pend_q <= 1'b0;
      k_low_q     <= BYTE_RST;
    end else if (commit) begin
      call_pend_q <= is_call1;
      if (is_call1) k_low_q <= ir_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Architectural registers
  // ----------------------------------------------------------------
  // Program counter: step per word, call target on second word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pc_q <= PC_RST;
    else if (commit) pc_q <= pc_next;
    else if (wr_take && paddr == OFF_PC) pc_q <= {pwdata[20:1], 1'b0};
  end

  // Accumulator, flags and bank selector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q   <= BYTE_RST;
      flags_q <= FLAGS_RST;
      bank_q  <= BANK_RST;
    end else if (commit) begin
      if (is_invert && !dest_reg) acc_q <= inv_val;
      if (is_clear) flags_q[FLAG_Z] <= 1'b1;
      if (is_invert) begin
        flags_q[FLAG_Z] <= (inv_val == BYTE_RST);
        flags_q[FLAG_N] <= inv_val[7];
      end
    end else if (wr_take) begin
      if (paddr == OFF_ACC)   acc_q   <= pwdata[7:0];
      if (paddr == OFF_FLAGS) flags_q <= pwdata[4:0];
      if (paddr == OFF_BANK)  bank_q  <= pwdata[3:0];
    end
  end

  // Shadow copies, taken only by a fast-save call
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accumulator_shadow_q   <= BYTE_RST;
      flags_shadow_q         <= FLAGS_RST;
      bank_selector_shadow_q <= BANK_RST;
    end else if (push_ph && is_call1 && fast_save) begin
      accumulator_shadow_q   <= acc_q;
      flags_shadow_q         <= flags_q;
      bank_selector_shadow_q <= bank_q;
    end
  end

  // Return stack push in the first call cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) stack_q[i] <= PC_RST;
    end else if (push_ph && is_call1) begin
      stack_q[sp_q] <= pc_q + PC_RETURN;
      sp_q          <= sp_next;
    end
  end

  // Data memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DM_DEPTH; i++) dm_q[i] <= BYTE_RST;
    end else if (dm_we) begin
      dm_q[dm_wa] <= dm_wd;
    end
  end

  // Control and index base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q   <= 1'b0;
      index_q <= INDEX_RST;
    end else if (wr_take) begin
      if (paddr == OFF_CTRL)  ext_q   <= pwdata[0];
      if (paddr == OFF_INDEX) index_q <= pwdata[11:0];
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // Free-running postscaler and counter; kick wins over expiry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_post_q          <= '0;
      watchdog_counter_q <= '0;
      timeout_flag_q     <= 1'b1;
      power_down_flag_q  <= 1'b1;
    end else if (commit && is_kick) begin
      wd_post_q          <= '0;
      watchdog_counter_q <= '0;
      timeout_flag_q     <= 1'b1;
      power_down_flag_q  <= 1'b1;
    end else begin
      wd_post_q <= wd_post_q + 1'b1;
      if (wd_post_wrap) watchdog_counter_q <= watchdog_counter_q + 1'b1;
      if (wd_expire) timeout_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // Read data selection
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFF_INSTR:  rd_mux[1:0]  = {call_pend_q, (st_q != ST_IDLE)};
      OFF_PC:     rd_mux[20:0] = pc_q;
      OFF_ACC:    rd_mux[7:0]  = acc_q;
      OFF_FLAGS:  rd_mux[4:0]  = flags_q;
      OFF_BANK:   rd_mux[3:0]  = bank_q;
      OFF_SHADOW: rd_mux[19:0] = {bank_selector_shadow_q, 3'h0, flags_shadow_q,
                                  accumulator_shadow_q};
      OFF_STACK: begin
        rd_mux[20:0]        = stack_q[sp_top];
        rd_mux[24+:SPW]     = sp_q;
      end
      OFF_WDOG: begin
        rd_mux[WD_CNT_W-1:0]    = watchdog_counter_q;
        rd_mux[8+:WD_POST_W]    = wd_post_q;
        rd_mux[WD_TMO_BIT]      = timeout_flag_q;
        rd_mux[WD_SLP_BIT]      = power_down_flag_q;
      end
      OFF_CTRL:   rd_mux[0]     = ext_q;
      OFF_INDEX:  rd_mux[11:0]  = index_q;
      default:    if (sel_dm) rd_mux[7:0] = dm_q[bus_idx];
    endcase
  end

  // Ready after one wait state, or at the end of an issued instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= plain | commit;
      pslverr_q <= plain & ~mapped;
      prdata_q  <= (plain & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign timeout_flag    = timeout_flag_q;
  assign power_down_flag = power_down_flag_q;

endmodule : ccc_core

/* File: ccc_core_props.sv */
// Port checker for the call / clear / invert / kick engine.
// Assumes one clock pclk and the async active-low reset presetn.
`timescale 1ns/100ps
module ccc_core_props import ccc_pkg::*; (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Status pins
  input wire logic        timeout_flag,
  input wire logic        power_down_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Call word tracking
  // ----------------------------------------------------------------
  logic instr_done;  // Instruction transfer completes
  logic await_d;     // Next instruction is a call second word
  logic await_q;
  assign instr_done = pready && psel && pwrite && (paddr == OFF_INSTR);
  assign await_d = instr_done ? (!await_q && pwdata[15:9] == OP_CALL) : await_q;
  // Follows the two-word pairing of calls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      await_q <= 1'b0;
    end else begin
      await_q <= await_d;
    end
  end
  // ----------------------------------------------------------------
  // Sequences and assertions
  // ----------------------------------------------------------------
  sequence instr_start;
    psel && $rose(penable) && pwrite && (paddr == OFF_INSTR);
  endsequence
  sequence instr_wait;
    !pready [*5] ##1 pready;
  endsequence
  sequence reg_start;
    psel && $rose(penable) && !(pwrite && paddr == OFF_INSTR);
  endsequence
  instr_latency_a: assert property (instr_start |-> instr_wait)
    else $error("instruction answer not five cycles after access");
  reg_latency_a: assert property (reg_start |=> pready)
    else $error("register answer not one cycle after access");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside a completing transfer");
  rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero outside read completion");
  unmapped_err_a: assert property (pready && paddr[11:10] == 2'h0 && paddr > OFF_INDEX
    |-> pslverr) else $error("unmapped address without error");
  mapped_ok_a: assert property (pready && paddr[1:0] == 2'h0 && paddr <= OFF_INDEX |-> !pslverr)
    else $error("mapped register answered with error");
  kick_flags_a: assert property (instr_done && !await_q && pwdata[15:0] == OP_KICK
    |-> timeout_flag && power_down_flag) else $error("kick left a flag low");
  pd_hold_a: assert property (!$fell(power_down_flag))
    else $error("power-down flag cleared");
endmodule : ccc_core_props

bind ccc_core ccc_core_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timeout_flag(timeout_flag),
  .power_down_flag(power_down_flag));

/* File: ccc_prog_mem.sv */
// Program memory model: supplies the instruction words the bench issues.
// Assumes the word is selected one clock before it is used.
`timescale 1ns/100ps
module ccc_prog_mem (
  // Word select
  input  wire logic [3:0]  idx,
  // Instruction word
  output logic      [15:0] word
);
  logic [15:0] rom [0:7];  // Stored program words
  assign word = rom[idx[2:0]];
  // Fixed program
  initial begin
    rom[0] = 16'h6A05;  // Clear, a=0, f=05
    rom[1] = 16'h6B07;  // Clear, a=1, f=07
    rom[2] = 16'h1C09;  // Invert to accumulator
    rom[3] = 16'h1E09;  // Invert back to register
    rom[4] = 16'hED45;  // Call first word, fast save, k low 45
    rom[5] = 16'hF123;  // Call second word, k high 123
    rom[6] = 16'hEC20;  // Call first word, no save, k low 20
    rom[7] = 16'h0004;  // Kick, also an odd second word
  end
endmodule : ccc_prog_mem

/* File: test_call_clear_complement_ops.sv */
// Self-checking bench for the instruction engine over APB.
// Assumes ccc_core with shortened watchdog counts and the prog memory model.
`timescale 1ns/100ps
module test_call_clear_complement_ops import ccc_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite;  // Clock, reset, APB controls
  logic [11:0] paddr;                                  // APB address
  logic [31:0] pwdata, prdata;                         // APB data
  logic        pready, pslverr, timeout_flag, power_down_flag;
  logic [3:0]  pm_idx;                                 // Program word select
  logic [15:0] pm_word;                                // Program word
  logic [31:0] rd_v;                                   // Raw read data
  logic        err_v;                                  // Raw error response
  int          failures, checks;
  ccc_core #(.WD_POST_W(2), .WD_CNT_W(2)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timeout_flag(timeout_flag),
    .power_down_flag(power_down_flag));
  ccc_prog_mem i_pm (.idx(pm_idx), .word(pm_word));
  // Closing report
  task automatic results;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      failures++;
      results();
    end
  endtask : apb
  // Read and compare
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask : rdc
  // Issue one program word
  task automatic ex(input logic [3:0] i);
    pm_idx <= i;
    @(posedge pclk);
    apb(1'b1, OFF_INSTR, {16'h0000, pm_word});
  endtask : ex
  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pm_idx = 4'h0;
    failures = 0;
    checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(OFF_ACC, 32'h0);
    chk({30'h0, timeout_flag, power_down_flag}, 32'h3);
    apb(1'b1, 12'h414, 32'h5A);
    apb(1'b1, OFF_FLAGS, 32'h10);
    ex(4'h0);
    rdc(12'h414, 32'h0);
    rdc(OFF_FLAGS, 32'h14);
    // Banked clear with extended mode on: must not take the indexed path
    apb(1'b1, OFF_BANK, 32'h3);
    apb(1'b1, OFF_CTRL, 32'h1);
    apb(1'b1, OFF_INDEX, 32'h10);
    apb(1'b1, 12'h41C, 32'h77);
    apb(1'b1, 12'h45C, 32'h44);
    ex(4'h1);
    rdc(12'h41C, 32'h0);
    rdc(12'h45C, 32'h44);
    apb(1'b1, 12'h454, 32'h33);
    apb(1'b1, 12'h414, 32'h66);
    ex(4'h0);
    rdc(12'h454, 32'h0);
    rdc(12'h414, 32'h66);
    apb(1'b1, OFF_CTRL, 32'h0);
    $display("clear tests done");
    apb(1'b1, 12'h424, 32'h13);
    ex(4'h2);
    rdc(OFF_ACC, 32'hEC);
    rdc(12'h424, 32'h13);
    rdc(OFF_FLAGS, 32'h10);
    ex(4'h3);
    rdc(12'h424, 32'hEC);
    $display("invert tests done");
    apb(1'b1, OFF_PC, 32'h100);
    apb(1'b1, OFF_ACC, 32'h55);
    ex(4'h4);
    rdc(OFF_STACK, 32'h0100_0104);
    rdc(OFF_SHADOW, 32'h0003_1055);
    rdc(OFF_PC, 32'h102);
    ex(4'h5);
    rdc(OFF_PC, 32'h2468A);
    apb(1'b1, OFF_ACC, 32'hAA);
    ex(4'h6);
    ex(4'h7);
    rdc(OFF_PC, 32'h840);
    rdc(OFF_STACK, 32'h0202_468E);
    rdc(OFF_SHADOW, 32'h0003_1055);
    $display("call tests done");
    repeat (40) @(posedge pclk);
    chk({31'h0, timeout_flag}, 32'h0);
    ex(4'h7);
    chk({30'h0, timeout_flag, power_down_flag}, 32'h3);
    // Flags set, counter zero; postscaler has run three clocks since the kick
    rdc(OFF_WDOG, 32'h0003_0300);
    $display("kick test done");
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, err_v}, 32'h1);
    chk(rd_v, 32'h0);
    $display("unmapped test done");
    results();
  end
endmodule : test_call_clear_complement_ops
